/* File: cbx_bus_master.sv */
// cbx_bus_master: external bus access logic of the processor, driven over APB.
// assumes bus inputs are synchronous to clk_sys; the bus clock is made here.
//
// Behaviour
// RULE_01: cache on at lock 11, locked at 01
// RULE_02: bus runs full or half core rate
// RULE_03: bus clock rising edge aligned at reset release
// RULE_04: test mode floats the bus clock pin
// RULE_05: bus outputs change only at bus rising edge
// RULE_06: answers never sampled in the prompting cycle
// RULE_07: page user outputs track translation, else low
// RULE_08: option outputs from instruction, low on fetches
// RULE_09: vector fetches drive user and option low
// RULE_10: fetches flagged, four-word block-aligned bursts
// RULE_11: branch on last word ends after one extra
// RULE_12: fetch defaults: read, strobes high, io low; io follows translation and I/O page on fetches too
// RULE_13: data accesses single, select low, direction shown
// RULE_14: write data driven from second cycle on
// RULE_15: data bus floats after write is ready
// RULE_16: reads take whole word, aligned inside
// RULE_17: narrow write data replicated across lanes
// RULE_18: strobes only on valid writes
// RULE_19: big-endian strobe encoding
// RULE_20: little-endian strobe encoding
// RULE_21: word strobes all low, development code none
// RULE_22: configuration bit 2 holds byte order
//
// Added by the designer: the APB slave port and the register addresses.
`default_nettype none
module cbx_bus_master (
    // clock and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // straps
    input wire logic halfRateSelect,
    input wire logic testMode,
    // bus clock pin
    output logic busClock,
    output logic busClockOe_n,
    // address and access qualifiers
    output logic [31:0] busAddr,
    output logic busReq_n,
    output logic busBurst,
    output logic busReadNotWrite,
    output logic busInstrNotData,
    output logic busIoSelect,
    output logic [3:0] byteWriteStrobes_n,
    output logic [2:0] accessOptionCode,
    output logic [1:0] pageUserOutputs,
    // instruction/data bus
    input wire logic [31:0] busDataIn,
    output logic [31:0] busDataOut,
    output logic busDataOe_n,
    input wire logic busReady_n,
    input wire logic busError_n
);
    import cbx_pkg::*;

    // registers
    logic [31:0] cfg_reg, addr_reg, wdata_reg, rdata_reg, prdata_reg, busAddr_reg, dout_reg;
    logic [12:0] cmd_reg;
    logic [31:0] fetch_reg [4];
    logic goPend_reg, branch_reg, errFlag_reg, discFlag_reg, pready_reg, pslverr_reg;
    logic busClock_reg, busClockOe_n_reg, busReq_n_reg, busBurst_reg, busRw_reg, busId_reg;
    logic busIo_reg, doe_n_reg;
    cbx_state_e state_reg, state_next;
    logic [2:0] beat_reg, opt_reg;
    logic [3:0] bwe_n_reg;
    logic [1:0] user_reg;

    // apb decode
    wire logic apbSetup = psel & ~penable;
    wire logic apbDone = psel & penable & pready_reg;
    wire logic apbWr = apbDone & pwrite;
    wire logic isFetchWin = (paddr >= CBX_OFF_FETCH0) && (paddr <= CBX_OFF_FETCH3);
    wire logic addrMapped = (paddr <= CBX_OFF_RDATA || isFetchWin) && paddr[1:0] == 2'h0;
    wire logic busy = goPend_reg | (state_reg != CBX_IDLE);
    wire logic wrCfg = apbWr && paddr == CBX_OFF_CFG;
    wire logic wrAddr = apbWr && paddr == CBX_OFF_ADDR && !busy;
    wire logic wrWdata = apbWr && paddr == CBX_OFF_WDATA && !busy;
    wire logic wrCmdGo = apbWr && paddr == CBX_OFF_CMD && !busy;
    wire logic wrBranch = apbWr && paddr == CBX_OFF_CMD && busy && pwdata[CBX_CMD_BRANCH];
    wire logic wrStatus = apbWr && paddr == CBX_OFF_STATUS;

    // configuration view
    wire logic byteOrder = cfg_reg[CBX_CFG_BO]; // RULE_22
    wire logic [1:0] lockField = cfg_reg[CBX_CFG_IL_LO +: 2];
    wire logic cacheOff = cfg_reg[CBX_CFG_ID];
    wire logic cacheEnabled = !cacheOff && lockField == CBX_IL_ENABLE; // RULE_01
    wire logic cacheLocked = !cacheOff && lockField == CBX_IL_LOCK; // RULE_01
    wire logic [31:0] cfgWrite = pwdata & ((32'h3 << CBX_CFG_IL_LO) | (32'h1 << CBX_CFG_ID) |
                                           (32'h1 << CBX_CFG_BO));

    // command view
    wire logic [2:0] cmdOpt = cmd_reg[CBX_CMD_OPT_LO +: 3];
    wire logic cmdRead = cmd_reg[CBX_CMD_READ];
    wire logic cmdFetch = cmd_reg[CBX_CMD_FETCH];
    wire logic cmdVector = cmd_reg[CBX_CMD_VECTOR];
    wire logic cmdXlate = cmd_reg[CBX_CMD_XLATE];
    wire logic [1:0] cmdUser = cmd_reg[CBX_CMD_USER_LO +: 2];
    wire logic cmdIoPage = cmd_reg[CBX_CMD_IOPAGE];
    wire logic cmdProtV = cmd_reg[CBX_CMD_PROTV];
    wire logic cmdSigned = cmd_reg[CBX_CMD_SIGNED];
    wire logic isFetch = cmdFetch | cmdVector;

    // status and read mux
    wire logic [31:0] statusWord = {27'h0000000, discFlag_reg, errFlag_reg,
                                    cacheLocked, cacheEnabled, busy};
    wire logic [31:0] rdMux = (paddr == CBX_OFF_CFG) ? cfg_reg :
                              (paddr == CBX_OFF_ADDR) ? addr_reg :
                              (paddr == CBX_OFF_WDATA) ? wdata_reg :
                              (paddr == CBX_OFF_CMD) ? {19'h00000, cmd_reg} :
                              (paddr == CBX_OFF_STATUS) ? statusWord :
                              (paddr == CBX_OFF_RDATA) ? rdata_reg :
                              isFetchWin ? fetch_reg[paddr[3:2]] : 32'h0000_0000;

    // bus clock: tick marks core edges that are bus rising edges
    wire logic busTick = halfRateSelect | ~busClock_reg; // RULE_02 RULE_05

    // access qualifiers
    wire logic [31:0] blockBase = {addr_reg[31:4], 4'h0}; // RULE_10
    wire logic [2:0] beatNext = beat_reg + 3'h1;
    wire logic [31:0] nextBeatAddr = blockBase + {27'h0000000, beatNext, 2'h0};
    wire logic [31:0] startAddr = isFetch ? blockBase : addr_reg;
    wire logic [1:0] userOut = (cmdXlate && !cmdVector) ? cmdUser : 2'h0; // RULE_07 RULE_09
    wire logic [2:0] optOut = isFetch ? 3'h0 : cmdOpt; // RULE_08 RULE_09 RULE_12
    wire logic ioOut = cmdXlate && cmdIoPage; // RULE_12
    wire logic rwOut = isFetch | cmdRead; // RULE_12 RULE_13
    wire logic writeValid = !isFetch && !cmdRead && !cmdProtV; // RULE_18
    wire logic [3:0] strobeN;
    wire logic [31:0] alignedRead;
    wire logic [31:0] writeLanes = (cmdOpt == CBX_OPT_BYTE) ? {4{wdata_reg[7:0]}} :
                                   (cmdOpt == CBX_OPT_HALF) ? {2{wdata_reg[15:0]}} :
                                   wdata_reg; // RULE_17

    // burst control
    wire logic readyNow = (state_reg == CBX_WAIT) && !busReady_n;
    wire logic lastBeat = beat_reg == CBX_BURST_LAST;
    wire logic extraBeat = beat_reg == CBX_BURST_EXTRA;
    wire logic burstGoOn = isFetch && !extraBeat && (!lastBeat || branch_reg); // RULE_11

    cbx_strobe_enc u_strobe (
        .writeValid(writeValid),
        .byteOrder(byteOrder),
        .optCode(cmdOpt),
        .addrLow(addr_reg[1:0]),
        .strobeN(strobeN)
    );

    cbx_read_align u_align (
        .wordIn(busDataIn),
        .byteOrder(byteOrder),
        .optCode(cmdOpt),
        .addrLow(addr_reg[1:0]),
        .signExt(cmdSigned),
        .alignedOut(alignedRead)
    );

    // sequencer next state
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            CBX_IDLE: begin
                state_next = goPend_reg ? CBX_ADDR : CBX_IDLE;
            end
            CBX_ADDR: begin
                state_next = CBX_WAIT; // RULE_06
            end
            CBX_WAIT: begin
                if (!busReady_n && !burstGoOn) begin
                    state_next = CBX_END;
                end
            end
            CBX_END: begin
                state_next = CBX_IDLE;
            end
            default: begin
                state_next = CBX_IDLE;
            end
        endcase
    end

    // apb slave: one access cycle per transfer
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg <= 32'h0000_0000;
        end else begin
            pready_reg <= apbSetup;
            pslverr_reg <= apbSetup & ~addrMapped;
            prdata_reg <= (apbSetup && !pwrite) ? rdMux : 32'h0000_0000;
        end
    end

    // software registers
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            cfg_reg <= CBX_CFG_RESET;
            addr_reg <= 32'h0000_0000;
            wdata_reg <= 32'h0000_0000;
            cmd_reg <= 13'h0000;
        end else begin
            if (wrCfg) begin
                cfg_reg <= cfgWrite;
            end
            if (wrAddr) begin
                addr_reg <= pwdata;
            end
            if (wrWdata) begin
                wdata_reg <= pwdata;
            end
            if (wrCmdGo) begin
                cmd_reg <= pwdata[12:0];
            end
        end
    end

    // request and event flags; hardware set wins over software clear
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            goPend_reg <= 1'b0;
            branch_reg <= 1'b0;
            errFlag_reg <= 1'b0;
            discFlag_reg <= 1'b0;
        end else begin
            if (wrCmdGo) begin
                goPend_reg <= 1'b1;
            end else if (busTick && state_reg == CBX_IDLE) begin
                goPend_reg <= 1'b0;
            end
            if (wrBranch && isFetch && state_reg != CBX_END) begin
                branch_reg <= 1'b1;
            end else if (wrCmdGo) begin
                branch_reg <= 1'b0;
            end
            if (busTick && readyNow && !busError_n) begin
                errFlag_reg <= 1'b1;
            end else if (wrStatus && pwdata[CBX_ST_ERR]) begin
                errFlag_reg <= 1'b0;
            end
            if (busTick && readyNow && extraBeat) begin
                discFlag_reg <= 1'b1;
            end else if (wrStatus && pwdata[CBX_ST_DISC]) begin
                discFlag_reg <= 1'b0;
            end
        end
    end

    // bus clock pin
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            busClock_reg <= 1'b0; // RULE_03
            busClockOe_n_reg <= 1'b0;
        end else begin
            busClock_reg <= halfRateSelect | ~busClock_reg; // RULE_02 RULE_03
            busClockOe_n_reg <= testMode; // RULE_04
        end
    end

    // sequencer and bus outputs, updated only on bus rising edges
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            state_reg <= CBX_IDLE;
            beat_reg <= 3'h0;
            busAddr_reg <= 32'h0000_0000;
            busReq_n_reg <= 1'b1;
            busBurst_reg <= 1'b0;
            busRw_reg <= 1'b1;
            busId_reg <= 1'b0;
            busIo_reg <= 1'b0;
            bwe_n_reg <= 4'hF;
            opt_reg <= 3'h0;
            user_reg <= 2'h0;
            dout_reg <= 32'h0000_0000;
            doe_n_reg <= 1'b1;
            rdata_reg <= 32'h0000_0000;
        end else if (busTick) begin // RULE_05
            state_reg <= state_next;
            case (state_reg)
                CBX_IDLE: begin
                    if (goPend_reg) begin
                        beat_reg <= 3'h0;
                        busAddr_reg <= startAddr; // RULE_10
                        busReq_n_reg <= 1'b0;
                        busBurst_reg <= isFetch; // RULE_13
                        busRw_reg <= rwOut; // RULE_13
                        busId_reg <= isFetch; // RULE_10 RULE_13
                        busIo_reg <= ioOut;
                        bwe_n_reg <= isFetch ? 4'hF : strobeN; // RULE_12
                        opt_reg <= optOut; // RULE_08
                        user_reg <= userOut; // RULE_07
                    end
                end
                CBX_ADDR: begin
                    if (!rwOut) begin
                        dout_reg <= writeLanes; // RULE_14 RULE_17
                        doe_n_reg <= 1'b0; // RULE_14
                    end
                end
                CBX_WAIT: begin
                    if (!busReady_n) begin
                        if (burstGoOn) begin
                            beat_reg <= beatNext;
                            busAddr_reg <= nextBeatAddr;
                            busBurst_reg <= beatNext != CBX_BURST_EXTRA &&
                                            (beatNext != CBX_BURST_LAST || branch_reg);
                        end else begin
                            busReq_n_reg <= 1'b1;
                            busBurst_reg <= 1'b0;
                            doe_n_reg <= 1'b1; // RULE_15
                            busRw_reg <= 1'b1;
                            bwe_n_reg <= 4'hF;
                            opt_reg <= 3'h0;
                            user_reg <= 2'h0;
                            busIo_reg <= 1'b0;
                        end
                        if (!isFetch && cmdRead) begin
                            rdata_reg <= alignedRead; // RULE_16
                        end
                    end
                end
                CBX_END: begin
                    busId_reg <= 1'b0;
                end
                default: begin
                    busReq_n_reg <= 1'b1;
                    doe_n_reg <= 1'b1;
                end
            endcase
        end
    end

    // fetched block storage; the word past a terminated block is dropped
    always_ff @(posedge clk_sys) begin
        if (busTick && readyNow && isFetch && !extraBeat) begin // RULE_11
            fetch_reg[beat_reg[1:0]] <= busDataIn;
        end
    end

    // outputs
    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;
    assign busClock = busClock_reg;
    assign busClockOe_n = busClockOe_n_reg;
    assign busAddr = busAddr_reg;
    assign busReq_n = busReq_n_reg;
    assign busBurst = busBurst_reg;
    assign busReadNotWrite = busRw_reg;
    assign busInstrNotData = busId_reg;
    assign busIoSelect = busIo_reg;
    assign byteWriteStrobes_n = bwe_n_reg;
    assign accessOptionCode = opt_reg;
    assign pageUserOutputs = user_reg;
    assign busDataOut = dout_reg;
    assign busDataOe_n = doe_n_reg;
endmodule
`default_nettype wire

/* File: cbx_bus_master_bench.sv */
// cbx_bus_master_bench: self-checking bench for the external bus master.
// assumes cbx_mem_model answers on the external bus.
`default_nettype none
module cbx_bus_master_bench;
    timeunit 1ns;
    timeprecision 1ns;
    import cbx_pkg::*;
    `define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin err_count++; \
        $display("unexpected at %0t: %h vs %h", $time, g, e); end end
    logic clk_sys = 1'b0, sys_rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic halfRateSelect = 1'b0, testMode = 1'b0, errInject = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, busAddr, busDataIn, busDataOut, rd, mData;
    logic [3:0] waitCycles = 4'h1, byteWriteStrobes_n, mStb;
    logic pready, pslverr, busClock, busClockOe_n, busReq_n, busBurst, busReadNotWrite;
    logic busInstrNotData, busIoSelect, busDataOe_n, busReady_n, busError_n;
    logic [2:0] accessOptionCode, mOpt;
    logic [1:0] pageUserOutputs, mUser;
    int err_count = 0, num_checks = 0;
    cbx_bus_master uut (.clk_sys, .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .halfRateSelect, .testMode, .busClock, .busClockOe_n, .busAddr,
        .busReq_n, .busBurst, .busReadNotWrite, .busInstrNotData, .busIoSelect,
        .byteWriteStrobes_n, .accessOptionCode, .pageUserOutputs, .busDataIn, .busDataOut,
        .busDataOe_n, .busReady_n, .busError_n);
    cbx_mem_model mem (.clk_sys, .sys_rst, .busReq_n, .busAddr, .waitCycles, .errInject,
        .busDataIn, .busReady_n, .busError_n);
    initial forever #20 clk_sys = ~clk_sys;
    always @(posedge clk_sys) begin
        if (!busReq_n) {mStb, mOpt, mUser} <= {byteWriteStrobes_n, accessOptionCode, pageUserOutputs};
        if (!busDataOe_n) mData <= busDataOut;
    end
    task automatic conclude();
        $display("checks %0d, mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task automatic apb(logic wr, logic [7:0] a, logic [31:0] d);
        int n;
        @(posedge clk_sys);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, wr, a, d};
        @(posedge clk_sys);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) begin err_count++; conclude(); end
        rd = prdata;
        {psel, penable} <= 2'b00;
    endtask
    task automatic idle();
        for (int n = 0; n < 60; n++) begin
            apb(1'b0, CBX_OFF_STATUS, 32'h0);
            if (rd[CBX_ST_BUSY] === 1'b0) return;
        end
        err_count++;
        conclude();
    endtask
    function automatic logic [3:0] expStb(logic bo, logic [2:0] op, logic [1:0] a, logic pv);
        if (pv || op == CBX_OPT_DEV) return 4'hF;
        if (op == CBX_OPT_BYTE) return ~(4'h1 << (bo ? a : 2'h3 - a));
        if (op == CBX_OPT_HALF) return (a[1] == bo) ? 4'h3 : 4'hC;
        return 4'h0;
    endfunction
    function automatic logic [31:0] expRd(logic bo, logic [2:0] op, logic [1:0] a, logic s,
            logic [31:0] w);
        logic [31:0] v;
        v = w >> (op == CBX_OPT_HALF ? 16 * (bo ? a[1] : !a[1]) : 8 * (bo ? a : 2'h3 - a));
        if (op == CBX_OPT_BYTE) return {{24{s & v[7]}}, v[7:0]};
        if (op == CBX_OPT_HALF) return {{16{s & v[15]}}, v[15:0]};
        return w;
    endfunction
    task automatic access(logic bo, logic [2:0] op, logic [31:0] a, logic [31:0] d,
            logic rdOp, logic s, logic pv);
        apb(1'b1, CBX_OFF_CFG, {29'h0, bo, 2'h0});
        apb(1'b1, CBX_OFF_ADDR, a);
        apb(1'b1, CBX_OFF_WDATA, d);
        apb(1'b1, CBX_OFF_CMD, {19'h0, s, 1'b0, pv, 1'b0, 2'h1, 1'b1, 2'h0, rdOp, op});
        idle();
        `CHK(mOpt, op)
        `CHK(mUser, 2'h1)
        if (rdOp) begin
            apb(1'b0, CBX_OFF_RDATA, 32'h0);
            `CHK(rd, expRd(bo, op, a[1:0], s, {a[31:2], 2'h0} ^ 32'h5A3C_96E1))
        end else begin
            `CHK(mStb, expStb(bo, op, a[1:0], pv))
            `CHK(mData, op == CBX_OPT_BYTE ? {4{d[7:0]}} : op == CBX_OPT_HALF ? {2{d[15:0]}} : d)
        end
    endtask
    task automatic fetch(logic [31:0] a, logic vec);
        int i;
        apb(1'b1, CBX_OFF_ADDR, a);
        apb(1'b1, CBX_OFF_CMD, {22'h0, 1'b1, 2'h3, 1'b1, vec, 2'h2, 3'h5});
        if (vec) apb(1'b1, CBX_OFF_CMD, 32'h800);
        idle();
        `CHK(rd[CBX_ST_DISC], vec)
        `CHK(mUser, vec ? 2'h0 : 2'h3)
        `CHK(mOpt, 3'h0)
        for (i = 0; i < 4; i++) begin
            apb(1'b0, CBX_OFF_FETCH0 + 8'(4 * i), 32'h0);
            `CHK(rd, ({a[31:4], 4'h0} + 32'(4 * i)) ^ 32'h5A3C_96E1)
        end
    endtask
    initial begin
        repeat (100000) @(posedge clk_sys);
        err_count++;
        conclude();
    end
    initial begin
        int i, p;
        logic [31:0] r;
        void'($urandom(32'h8C96));
        for (p = 0; p < 2; p++) begin
            sys_rst <= 1'b1;
            halfRateSelect <= p[0];
            repeat (2) @(posedge clk_sys);
            sys_rst <= 1'b0;
            for (i = 0; i < 4; i++) begin
                apb(1'b1, CBX_OFF_CFG, {21'h0, i[0] ? 2'h1 : 2'h3, i[1], 8'h0});
                apb(1'b0, CBX_OFF_STATUS, 32'h0);
                `CHK(rd[2:1], i[1] ? 2'h0 : i[0] ? 2'h2 : 2'h1)
            end
            apb(1'b1, CBX_OFF_CFG, 32'h4);
            apb(1'b0, CBX_OFF_CFG, 32'h0);
            `CHK(rd, 32'h0000_0004)
            for (i = 0; i < 64; i++)
                access(i[5], i[4:2], {30'h2A5, i[1:0]}, 32'h89AB_CDEF, 1'b0, 1'b0, i[5:2] == 4'h9);
            for (i = 0; i < 24; i++) begin
                r = $urandom;
                waitCycles <= 4'h1 + 4'(r[3:2]);
                errInject <= !r[5] && r[13] && r[14];
                access(r[4], r[5] && r[9:8] == 2'h3 ? 3'h0 : {!r[5] && r[10], r[9:8]}, $urandom,
                    $urandom, r[5], r[6], !r[5] && r[11] && r[12]);
            end
            errInject <= 1'b0;
            fetch(32'h0000_1234, 1'b0);
            fetch($urandom, 1'b1);
            @(posedge clk_sys);
            testMode <= 1'b1;
            repeat (2) @(posedge clk_sys);
            `CHK(busClockOe_n, 1'b1)
            testMode <= 1'b0;
        end
        conclude();
    end
endmodule
`default_nettype wire

/* File: cbx_bus_master_props.sv */
// cbx_bus_master_props: port checks of the external bus master.
// assumes it is bound into cbx_bus_master; one clock, reset active high.
`default_nettype none
module cbx_bus_master_props (
    // clock and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    // straps and bus outputs
    input wire logic halfRateSelect,
    input wire logic testMode,
    input wire logic busClock,
    input wire logic busClockOe_n,
    input wire logic [31:0] busAddr,
    input wire logic busReq_n,
    input wire logic busBurst,
    input wire logic busReadNotWrite,
    input wire logic busInstrNotData,
    input wire logic [3:0] byteWriteStrobes_n,
    input wire logic [2:0] accessOptionCode,
    input wire logic [1:0] pageUserOutputs,
    input wire logic busDataOe_n
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    AST_CLK_FLOAT: assert property (testMode |=> busClockOe_n)
        else $error("bus clock pin driven in test mode");
    AST_FULL_RATE: assert property (halfRateSelect && !$past(sys_rst) |-> busClock)
        else $error("bus clock not at core rate");
    AST_HALF_TICK: assert property (!halfRateSelect && !$past(halfRateSelect)
        && !$rose(busClock) |-> $stable(busAddr) && $stable(busReq_n)) else $error("mid tick");
    AST_FETCH_DFLT: assert property (!busReq_n && busInstrNotData |-> busReadNotWrite
        && byteWriteStrobes_n == 4'hF && accessOptionCode == 3'h0) else $error("fetch levels");
    AST_IDLE_LOW: assert property (busReq_n |-> pageUserOutputs == 2'h0
        && accessOptionCode == 3'h0 && byteWriteStrobes_n == 4'hF) else $error("idle levels");
    AST_STB_WRITE: assert property (byteWriteStrobes_n != 4'hF |-> !busReq_n
        && !busReadNotWrite) else $error("strobes outside write");
    AST_DATA_LATE: assert property ($fell(busReq_n) && !busReadNotWrite && halfRateSelect
        |-> busDataOe_n ##1 !busDataOe_n) else $error("write data timing");
    AST_DATA_FLOAT: assert property (!busDataOe_n |-> !busReq_n && !busReadNotWrite)
        else $error("data bus driven outside write");
    AST_BURST_ALIGN: assert property ($fell(busReq_n) |-> busBurst == busInstrNotData
        && (!busInstrNotData || busAddr[3:0] == 4'h0)) else $error("burst start");
    cover property ($fell(busReq_n) && !busReadNotWrite);
    cover property ($fell(busReq_n) && busInstrNotData && !halfRateSelect);
    cover property (byteWriteStrobes_n == 4'h7);
endmodule
bind cbx_bus_master cbx_bus_master_props chk (.clk_sys, .sys_rst, .halfRateSelect, .testMode,
    .busClock, .busClockOe_n, .busAddr, .busReq_n, .busBurst, .busReadNotWrite,
    .busInstrNotData, .byteWriteStrobes_n, .accessOptionCode, .pageUserOutputs, .busDataOe_n);
`default_nettype wire

/* File: cbx_mem_model.sv */
// cbx_mem_model: memory on the external bus, answering after a set wait.
// assumes the master holds a request until the final ready is taken.
`default_nettype none
module cbx_mem_model (
    // clock and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    // request and test controls
    input wire logic busReq_n,
    input wire logic [31:0] busAddr,
    input wire logic [3:0] waitCycles,
    input wire logic errInject,
    // answer
    output logic [31:0] busDataIn,
    output logic busReady_n,
    output logic busError_n
);
    logic [3:0] cnt;
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            cnt <= 4'h0;
        end else begin
            cnt <= busReq_n ? 4'h0 : cnt + 4'(cnt != 4'hF);
        end
    end
    // not ready in the cycle the request appears unless waitCycles is 0
    assign busReady_n = busReq_n || cnt < waitCycles;
    // whole aligned word, inverted while not answering
    assign busDataIn = {busAddr[31:2], 2'h0} ^ 32'h5A3C_96E1 ^ {32{busReady_n}};
    assign busError_n = !(errInject && !busReady_n);
endmodule
`default_nettype wire

/* File: cbx_pkg.sv */
// cbx_pkg: constants, register map and state type for the external bus master.
// assumes a single core clock domain and an APB register port.
`default_nettype none
package cbx_pkg;
    // register byte addresses
    localparam logic [7:0] CBX_OFF_CFG = 8'h00;
    localparam logic [7:0] CBX_OFF_ADDR = 8'h04;
    localparam logic [7:0] CBX_OFF_WDATA = 8'h08;
    localparam logic [7:0] CBX_OFF_CMD = 8'h0C;
    localparam logic [7:0] CBX_OFF_STATUS = 8'h10;
    localparam logic [7:0] CBX_OFF_RDATA = 8'h14;
    localparam logic [7:0] CBX_OFF_FETCH0 = 8'h20;
    localparam logic [7:0] CBX_OFF_FETCH3 = 8'h2C;
    // configuration fields
    localparam int CBX_CFG_BO = 2;
    localparam int CBX_CFG_ID = 8;
    localparam int CBX_CFG_IL_LO = 9;
    localparam logic [31:0] CBX_CFG_RESET = 32'h0000_0000;
    localparam logic [1:0] CBX_IL_ENABLE = 2'h3;
    localparam logic [1:0] CBX_IL_LOCK = 2'h1;
    // command fields
    localparam int CBX_CMD_OPT_LO = 0;
    localparam int CBX_CMD_READ = 3;
    localparam int CBX_CMD_FETCH = 4;
    localparam int CBX_CMD_VECTOR = 5;
    localparam int CBX_CMD_XLATE = 6;
    localparam int CBX_CMD_USER_LO = 7;
    localparam int CBX_CMD_IOPAGE = 9;
    localparam int CBX_CMD_PROTV = 10;
    localparam int CBX_CMD_BRANCH = 11;
    localparam int CBX_CMD_SIGNED = 12;
    // status fields
    localparam int CBX_ST_BUSY = 0;
    localparam int CBX_ST_ERR = 3;
    localparam int CBX_ST_DISC = 4;
    // access option codes
    localparam logic [2:0] CBX_OPT_WORD = 3'h0;
    localparam logic [2:0] CBX_OPT_BYTE = 3'h1;
    localparam logic [2:0] CBX_OPT_HALF = 3'h2;
    localparam logic [2:0] CBX_OPT_DEV = 3'h6;
    // instruction burst
    localparam logic [2:0] CBX_BURST_LAST = 3'h3;
    localparam logic [2:0] CBX_BURST_EXTRA = 3'h4;
    typedef enum logic [1:0] {
        CBX_IDLE,
        CBX_ADDR,
        CBX_WAIT,
        CBX_END
    } cbx_state_e;
endpackage
`default_nettype wire

/* File: cbx_read_align.sv */
// cbx_read_align: picks byte or half-word out of a returned word and extends it.
// assumes the bus always returns a whole aligned word.
`default_nettype none
module cbx_read_align (
    // returned word and access description
    input wire logic [31:0] wordIn,
    input wire logic byteOrder,
    input wire logic [2:0] optCode,
    input wire logic [1:0] addrLow,
    input wire logic signExt,
    // aligned result
    output logic [31:0] alignedOut
);
    import cbx_pkg::*;
    wire logic [1:0] byteLane = byteOrder ? addrLow : 2'h3 - addrLow;
    wire logic upperHalf = byteOrder ? addrLow[1] : ~addrLow[1];
    wire logic [7:0] byteVal = wordIn[{byteLane, 3'h0} +: 8];
    wire logic [15:0] halfVal = upperHalf ? wordIn[31:16] : wordIn[15:0];
    assign alignedOut = (optCode == CBX_OPT_BYTE) ?
                        {{24{signExt & byteVal[7]}}, byteVal} :
                        (optCode == CBX_OPT_HALF) ?
                        {{16{signExt & halfVal[15]}}, halfVal} : wordIn; // RULE_16
endmodule
`default_nettype wire

/* File: cbx_strobe_enc.sv */
// cbx_strobe_enc: active-low byte write strobes from option, address and byte order.
// assumes all inputs are stable for the access; purely combinational.
`default_nettype none
module cbx_strobe_enc (
    // access description
    input wire logic writeValid,
    input wire logic byteOrder,
    input wire logic [2:0] optCode,
    input wire logic [1:0] addrLow,
    // strobes
    output logic [3:0] strobeN
);
    import cbx_pkg::*;
    wire logic [1:0] byteLane = byteOrder ? addrLow : 2'h3 - addrLow; // RULE_19 RULE_20
    wire logic upperHalf = byteOrder ? addrLow[1] : ~addrLow[1]; // RULE_19 RULE_20
    wire logic [3:0] byteMask = ~(4'h1 << byteLane);
    wire logic [3:0] halfMask = upperHalf ? 4'h3 : 4'hC;
    wire logic [3:0] codeMask = (optCode == CBX_OPT_BYTE) ? byteMask :
        (optCode == CBX_OPT_HALF) ? halfMask : (optCode == CBX_OPT_DEV) ? 4'hF : 4'h0; // RULE_21
    assign strobeN = writeValid ? codeMask : 4'hF; // RULE_18
endmodule
`default_nettype wire
